// ### shared/hwm_pkg.sv
// Constants and carrier types for the host window mapper
package hwm_pkg;

    // Host physical addresses (20-bit real-mode space)
    localparam logic [19:0] HWM_TEXT_COLOR_BASE = 20'hB8000;
    localparam logic [19:0] HWM_TEXT_MONO_BASE  = 20'hB0000;
    localparam logic [19:0] HWM_GFX_BASE        = 20'hA0000;
    localparam logic [19:0] HWM_APER1_BASE      = 20'hA8000;
    localparam logic [19:0] HWM_TEXT_SIZE       = 20'h08000;
    localparam logic [19:0] HWM_GFX_SIZE        = 20'h10000;
    localparam logic [19:0] HWM_WIDE_SIZE       = 20'h20000;
    localparam logic [19:0] HWM_APER_SIZE       = 20'h08000;

    // Display memory: up to 1M bytes, four planes of up to 256K each
    localparam int HWM_DM_AW    = 20;
    localparam int HWM_PLANE_AW = 18;
    localparam int HWM_PAGE_W   = 4;
    localparam int HWM_PAGE64_SHIFT = 16;
    localparam int HWM_PAGE32_SHIFT = 15;
    localparam logic [3:0] HWM_ALL_PLANES = 4'hF;
    localparam logic [3:0] HWM_PLANE_CHAR = 4'h1;
    localparam logic [3:0] HWM_PLANE_ATTR = 4'h2;
    localparam logic [3:0] HWM_PLANE_FONT = 4'h4;

    // Attribute byte fields
    localparam int HWM_AT_BLINK = 7;
    localparam int HWM_AT_BG_R  = 6;
    localparam int HWM_AT_BG_G  = 5;
    localparam int HWM_AT_BG_B  = 4;
    localparam int HWM_AT_HI    = 3;
    localparam int HWM_AT_FG_R  = 2;
    localparam int HWM_AT_FG_G  = 1;
    localparam int HWM_AT_FG_B  = 0;
    localparam int HWM_FONT_PTR_W = 3;
    localparam int HWM_FONT_ROW_W = 5;

    typedef enum logic [1:0] {
        HWM_MAP_TEXT,
        HWM_MAP_PLANAR,
        HWM_MAP_PACKED
    } hwm_map_mode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } hwm_host_req_t;

    typedef struct packed {
        logic                    valid;
        logic                    write;
        logic [3:0]              plane_en;
        logic [HWM_DM_AW-1:0]    addr;
        logic [7:0]              wdata;
    } hwm_mem_req_t;

    typedef struct packed {
        logic       fg_r;
        logic       fg_g;
        logic       fg_b;
        logic       fg_hi;
        logic       fg_blink;
        logic       bg_r;
        logic       bg_g;
        logic       bg_b;
        logic       bg_hi;
        logic [HWM_FONT_PTR_W-1:0] font_set;
    } hwm_attr_t;

endpackage

// ### src/hwm_window_mapper.sv
// Host window decode, page mapping and text fetch/attribute decode
`timescale 1ns/1ps
module hwm_window_mapper
    import hwm_pkg::*;
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    // Configuration
    input  wire hwm_map_mode_t           map_mode,
    input  wire logic                    mono_text,
    input  wire logic                    wide_window_en,
    input  wire logic                    ext_regs_present,
    input  wire logic                    blink_enable,
    input  wire logic                    blink_phase,
    input  wire logic [5:0]              font_set_select_reg,
    input  wire logic [HWM_PAGE_W-1:0]   planar_page_select_reg,
    input  wire logic [HWM_PAGE_W-1:0]   aper0_rd_page,
    input  wire logic [HWM_PAGE_W-1:0]   aper0_wr_page,
    input  wire logic [HWM_PAGE_W-1:0]   aper1_rd_page,
    input  wire logic [HWM_PAGE_W-1:0]   aper1_wr_page,
    // Host side
    input  wire hwm_host_req_t           host_req,
    output hwm_mem_req_t                 mem_req,
    output logic                         host_hit,
    // Text display fetch
    input  wire logic                    fetch_req,
    input  wire logic [HWM_PLANE_AW-1:0] fetch_addr,
    input  wire logic [7:0]              plane0_rdata,
    input  wire logic [7:0]              plane1_rdata,
    input  wire logic [HWM_FONT_ROW_W-1:0] font_row,
    output logic [HWM_PLANE_AW-1:0]      font_addr,
    output logic                         font_addr_valid,
    output hwm_attr_t                    attr_out
);

    // Window decode: returns hit when the address lies within the window
    function automatic logic in_range(input logic [19:0] a,
                                      input logic [19:0] base,
                                      input logic [19:0] size);
        in_range = (a >= base) && (a < (base + size));
    endfunction

    // Page base plus offset, per page size
    function automatic logic [HWM_DM_AW-1:0] paged(input logic [HWM_PAGE_W-1:0] pg,
                                                   input logic [19:0] off,
                                                   input int shift);
        logic [HWM_DM_AW-1:0] base;
        base  = HWM_DM_AW'({16'h0000, pg} << shift);
        paged = base + off[HWM_DM_AW-1:0];
    endfunction

    logic [19:0]          a;
    logic                 hit;
    logic [19:0]          off;
    logic [3:0]           planes;
    logic [HWM_DM_AW-1:0] dm_addr;

    always_comb begin
        a       = host_req.addr;
        hit     = 1'b0;
        off     = 20'h00000;
        planes  = HWM_ALL_PLANES;
        dm_addr = '0;
        unique case (map_mode)
            HWM_MAP_TEXT: begin
                // 32K window, colour or mono base
                if (mono_text) begin
                    hit = in_range(a, HWM_TEXT_MONO_BASE, HWM_TEXT_SIZE);
                    off = a - HWM_TEXT_MONO_BASE;
                end else begin
                    hit = in_range(a, HWM_TEXT_COLOR_BASE, HWM_TEXT_SIZE);
                    off = a - HWM_TEXT_COLOR_BASE;
                end
                // Even byte is code (plane 0), odd byte is attribute (plane 1)
                planes  = off[0] ? HWM_PLANE_ATTR : HWM_PLANE_CHAR;
                dm_addr = HWM_DM_AW'(off >> 1);
            end
            HWM_MAP_PLANAR: begin
                // Default 64K; 128K only when software enables it
                if (wide_window_en) begin
                    hit = in_range(a, HWM_GFX_BASE, HWM_WIDE_SIZE);
                    off = a - HWM_GFX_BASE;
                    dm_addr = HWM_DM_AW'(off);
                end else if (ext_regs_present) begin
                    hit = in_range(a, HWM_GFX_BASE, HWM_GFX_SIZE);
                    off = a - HWM_GFX_BASE;
                    dm_addr = paged(planar_page_select_reg, off,
                                    HWM_PAGE64_SHIFT);
                end else begin
                    hit = in_range(a, HWM_GFX_BASE, HWM_GFX_SIZE);
                    if (a < HWM_APER1_BASE) begin
                        off = a - HWM_GFX_BASE;
                        dm_addr = paged(host_req.write ? aper0_wr_page : aper0_rd_page,
                                        off, HWM_PAGE32_SHIFT);
                    end else begin
                        off = a - HWM_APER1_BASE;
                        dm_addr = paged(host_req.write ? aper1_wr_page : aper1_rd_page,
                                        off, HWM_PAGE32_SHIFT);
                    end
                end
                // Same address to all four planes; pixel is one bit per plane
                planes = HWM_ALL_PLANES;
            end
            HWM_MAP_PACKED: begin
                // Two 32K apertures, each with its own read and write page
                hit = in_range(a, HWM_GFX_BASE, HWM_GFX_SIZE);
                if (a < HWM_APER1_BASE) begin
                    off = a - HWM_GFX_BASE;
                    dm_addr = paged(host_req.write ? aper0_wr_page : aper0_rd_page,
                                    off, HWM_PAGE32_SHIFT);
                end else begin
                    off = a - HWM_APER1_BASE;
                    dm_addr = paged(host_req.write ? aper1_wr_page : aper1_rd_page,
                                    off, HWM_PAGE32_SHIFT);
                end
                // Consecutive linear bytes per pixel
                planes = HWM_ALL_PLANES;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Host request to display memory, one cycle latency
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_req  <= '0;
            host_hit <= 1'b0;
        end else if (clk_en) begin
            mem_req.valid    <= host_req.valid && hit;
            mem_req.write    <= host_req.write;
            mem_req.plane_en <= planes;
            mem_req.addr     <= dm_addr;
            mem_req.wdata    <= host_req.wdata;
            host_hit         <= host_req.valid && hit;
        end
    end

    // Character font lookup and attribute decode for display
    logic [HWM_FONT_PTR_W-1:0] set_sel;
    logic [7:0]                at;
    always_comb begin
        at = plane1_rdata;
        set_sel = at[HWM_AT_HI] ? {font_set_select_reg[5], font_set_select_reg[3:2]}
                                : {font_set_select_reg[4], font_set_select_reg[1:0]};
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            font_addr       <= '0;
            font_addr_valid <= 1'b0;
        end else if (clk_en) begin
            font_addr_valid <= fetch_req;
            // Code and attribute of one position fetched together
            font_addr <= {set_sel, plane0_rdata, font_row, 2'b00};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            attr_out <= '0;
        end else if (clk_en && fetch_req) begin
            attr_out.bg_r  <= at[HWM_AT_BG_R];
            attr_out.bg_g  <= at[HWM_AT_BG_G];
            attr_out.bg_b  <= at[HWM_AT_BG_B];
            attr_out.fg_r  <= at[HWM_AT_FG_R];
            attr_out.fg_g  <= at[HWM_AT_FG_G];
            attr_out.fg_b  <= at[HWM_AT_FG_B];
            attr_out.fg_hi <= at[HWM_AT_HI];
            attr_out.font_set <= set_sel;
            // Bit 7 blinks foreground, or highlights background
            attr_out.fg_blink <= blink_enable && at[HWM_AT_BLINK] && blink_phase;
            attr_out.bg_hi    <= !blink_enable && at[HWM_AT_BLINK];
        end
    end

    // Assertions
    sequence s_host_hit;
        host_req.valid && hit;
    endsequence

    AST_OUTSIDE_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && host_req.valid && !hit |=> !mem_req.valid)
        else $error("Access outside window reached memory");
    AST_HIT_FORWARDED: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and clk_en |=> mem_req.valid && mem_req.addr == $past(dm_addr))
        else $error("Window hit not forwarded");
    AST_TEXT_EVEN_CHAR: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and (clk_en && map_mode == HWM_MAP_TEXT && !host_req.addr[0])
        |=> mem_req.plane_en == HWM_PLANE_CHAR)
        else $error("Even text byte not in plane 0");
    AST_TEXT_ODD_ATTR: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and (clk_en && map_mode == HWM_MAP_TEXT && host_req.addr[0])
        |=> mem_req.plane_en == HWM_PLANE_ATTR)
        else $error("Odd text byte not in plane 1");
    AST_TEXT_32K: assert property (@(posedge ref_clk) disable iff (rst)
        map_mode == HWM_MAP_TEXT && hit |-> (mono_text ? host_req.addr[19:15] == 5'h16
                                                       : host_req.addr[19:15] == 5'h17))
        else $error("Text window decode wrong");
    AST_GFX_64K: assert property (@(posedge ref_clk) disable iff (rst)
        map_mode != HWM_MAP_TEXT && !wide_window_en && hit |-> host_req.addr[19:16] == 4'hA)
        else $error("Graphics window decode wrong");
    AST_PLANAR_ALL: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and (clk_en && map_mode == HWM_MAP_PLANAR)
        |=> mem_req.plane_en == HWM_ALL_PLANES)
        else $error("Planar access not to all planes");
    AST_WIDE_128K: assert property (@(posedge ref_clk) disable iff (rst)
        map_mode == HWM_MAP_PLANAR && wide_window_en && host_req.addr[19:17] == 3'h5 |-> hit)
        else $error("128K window not decoded");
    AST_BLINK_BG: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && fetch_req && !blink_enable && plane1_rdata[7]
        |=> attr_out.bg_hi && !attr_out.fg_blink)
        else $error("Bit 7 background highlight wrong");
    AST_FONT_FETCH: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && fetch_req |=> font_addr_valid && font_addr[14:7] == $past(plane0_rdata))
        else $error("Font address not from character code");

    // Per-mode request sequences and the fetch sequence used by the checks below
    sequence s_text_hit;
        clk_en && map_mode == HWM_MAP_TEXT && host_req.valid && hit;
    endsequence

    sequence s_planar_hit;
        clk_en && map_mode == HWM_MAP_PLANAR && host_req.valid && hit;
    endsequence

    sequence s_packed_hit;
        clk_en && map_mode == HWM_MAP_PACKED && host_req.valid && hit;
    endsequence

    sequence s_fetch;
        clk_en && fetch_req;
    endsequence

    // Text: two host bytes per character share one plane address; then write data and hit flag in every mode
    AST_TEXT_HALF_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        s_text_hit |=> mem_req.addr == {6'h00, $past(host_req.addr[14:1])})
        else $error("Text plane address not host offset halved");
    AST_TEXT_NO_FONT: assert property (@(posedge ref_clk) disable iff (rst)
        s_text_hit |=> (mem_req.plane_en & HWM_PLANE_FONT) == 4'h0)
        else $error("Text host byte reached the font plane");
    AST_WRITE_DATA: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and (clk_en && host_req.write)
        |=> mem_req.write && mem_req.wdata == $past(host_req.wdata))
        else $error("Host write data not forwarded");
    AST_HIT_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
        s_host_hit and clk_en |=> host_hit)
        else $error("Window hit not flagged");
    AST_HIT_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && !host_req.valid |=> !host_hit && !mem_req.valid)
        else $error("Hit reported without a request");

    // Planar paging and the 128K window
    AST_PAGE64_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        s_planar_hit and (ext_regs_present && !wide_window_en)
        |=> mem_req.addr == {$past(planar_page_select_reg), $past(host_req.addr[15:0])})
        else $error("Planar page base wrong");
    AST_WIDE_DIRECT: assert property (@(posedge ref_clk) disable iff (rst)
        s_planar_hit and wide_window_en
        |=> mem_req.addr == {3'h0, $past(host_req.addr[16:0])})
        else $error("128K window offset wrong");
    AST_STANDARD_64K: assert property (@(posedge ref_clk) disable iff (rst)
        map_mode == HWM_MAP_PLANAR && !wide_window_en && host_req.addr[19:16] == 4'hB |-> !hit)
        else $error("Window above 64K decoded without the 128K option");
    AST_NO_EXT_APER: assert property (@(posedge ref_clk) disable iff (rst)
        s_planar_hit and (!ext_regs_present && !wide_window_en && host_req.write
                          && !host_req.addr[15])
        |=> mem_req.addr == {1'b0, $past(aper0_wr_page), $past(host_req.addr[14:0])})
        else $error("Planar aperture paging wrong");

    // Packed apertures, separate read and write pages
    AST_APER0_WR: assert property (@(posedge ref_clk) disable iff (rst)
        s_packed_hit and (host_req.write && !host_req.addr[15])
        |=> mem_req.addr == {1'b0, $past(aper0_wr_page), $past(host_req.addr[14:0])})
        else $error("Aperture 0 write page wrong");
    AST_APER0_RD: assert property (@(posedge ref_clk) disable iff (rst)
        s_packed_hit and (!host_req.write && !host_req.addr[15])
        |=> mem_req.addr == {1'b0, $past(aper0_rd_page), $past(host_req.addr[14:0])})
        else $error("Aperture 0 read page wrong");
    AST_APER1_RD: assert property (@(posedge ref_clk) disable iff (rst)
        s_packed_hit and (!host_req.write && host_req.addr[15])
        |=> mem_req.addr == {1'b0, $past(aper1_rd_page), $past(host_req.addr[14:0])})
        else $error("Aperture 1 read page wrong");
    AST_APER1_WR: assert property (@(posedge ref_clk) disable iff (rst)
        s_packed_hit and (host_req.write && host_req.addr[15])
        |=> mem_req.addr == {1'b0, $past(aper1_wr_page), $past(host_req.addr[14:0])})
        else $error("Aperture 1 write page wrong");
    AST_PACKED_ALL: assert property (@(posedge ref_clk) disable iff (rst)
        s_packed_hit |=> mem_req.plane_en == HWM_ALL_PLANES)
        else $error("Packed access not linear across planes");

    // Attribute decode, font row and font address valid
    AST_ATTR_COLOURS: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch |=> {attr_out.bg_r, attr_out.bg_g, attr_out.bg_b} == $past(plane1_rdata[6:4])
            && {attr_out.fg_r, attr_out.fg_g, attr_out.fg_b} == $past(plane1_rdata[2:0]))
        else $error("Attribute colour bits wrong");
    AST_ATTR_HI: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch |=> attr_out.fg_hi == $past(plane1_rdata[HWM_AT_HI]))
        else $error("Highlight bit wrong");
    AST_FONT_SET_HI: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch and plane1_rdata[HWM_AT_HI]
        |=> attr_out.font_set == {$past(font_set_select_reg[5]), $past(font_set_select_reg[3:2])})
        else $error("Second character set not selected");
    AST_FONT_SET_LO: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch and !plane1_rdata[HWM_AT_HI]
        |=> attr_out.font_set == {$past(font_set_select_reg[4]), $past(font_set_select_reg[1:0])})
        else $error("First character set not selected");
    AST_BLINK_FG: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch and (blink_enable && plane1_rdata[HWM_AT_BLINK] && blink_phase)
        |=> attr_out.fg_blink && !attr_out.bg_hi)
        else $error("Bit 7 foreground blink wrong");
    AST_FONT_ROW: assert property (@(posedge ref_clk) disable iff (rst)
        s_fetch |=> font_addr[6:2] == $past(font_row))
        else $error("Font row not in font address");
    AST_FETCH_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && !fetch_req |=> !font_addr_valid)
        else $error("Font address valid without a fetch");

endmodule // hwm_window_mapper

// ### testbench/hwm_host_model.sv
// Host processor model that places one-cycle memory requests on the host bus
`timescale 1ns/1ps
module hwm_host_model
    import hwm_pkg::*;
(
    // Clock
    input  wire logic          ref_clk,
    // Request from the bench
    input  wire logic          go,
    input  wire logic          wr,
    input  wire logic [19:0]   addr,
    input  wire logic [7:0]    wd,
    // Host bus
    output hwm_host_req_t      host_req
);
    logic [19:0] last_addr_r;
    logic [7:0]  last_data_r;

    always_ff @(posedge ref_clk) begin
        if (go) begin
            last_addr_r <= addr;
            last_data_r <= wd;
        end
    end

    // Idle bus shows the inverse of the last request, never a stale copy
    always_comb begin
        host_req.valid = go;
        host_req.write = go ? wr : ~wr;
        host_req.addr  = go ? addr : ~last_addr_r;
        host_req.wdata = go ? wd : ~last_data_r;
    end
endmodule // hwm_host_model

// ### testbench/test_vga_host_window_mapper.sv
// Self-checking bench for the host window mapper
`timescale 1ns/1ps
module test_vga_host_window_mapper;
    import hwm_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, mono = 1'b0, wide = 1'b0, ext = 1'b1, blink = 1'b0;
    logic go = 1'b0, wr = 1'b0, fetch = 1'b0, bph = 1'b0;
    hwm_map_mode_t mode = HWM_MAP_TEXT;
    logic [5:0]  fsel = 6'h00;
    logic [3:0]  ppg = 4'h0, a0r = 4'h0, a0w = 4'h0, a1r = 4'h0, a1w = 4'h0;
    logic [19:0] addr = 20'h00000;
    logic [7:0]  wd = 8'h00, p0 = 8'h00, p1 = 8'h00;
    logic [4:0]  row = 5'h00;
    hwm_host_req_t host_req;
    hwm_mem_req_t  mem_req;
    hwm_attr_t     attr;
    logic          hit, fvalid;
    logic [17:0]   faddr;
    int error_cnt = 0, n_checks = 0;

    initial forever #5 ref_clk = ~ref_clk;

    hwm_host_model u_hwm_host_model (.ref_clk(ref_clk), .go(go), .wr(wr), .addr(addr),
        .wd(wd), .host_req(host_req));

    hwm_window_mapper u_hwm_window_mapper (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
        .map_mode(mode), .mono_text(mono), .wide_window_en(wide), .ext_regs_present(ext),
        .blink_enable(blink), .blink_phase(bph), .font_set_select_reg(fsel),
        .planar_page_select_reg(ppg), .aper0_rd_page(a0r), .aper0_wr_page(a0w),
        .aper1_rd_page(a1r), .aper1_wr_page(a1w), .host_req(host_req), .mem_req(mem_req),
        .host_hit(hit), .fetch_req(fetch), .fetch_addr(18'h00000), .plane0_rdata(p0),
        .plane1_rdata(p1), .font_row(row), .font_addr(faddr), .font_addr_valid(fvalid),
        .attr_out(attr));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One host request; answer is looked at in the cycle after it is taken
    task automatic req(input logic w, input logic [19:0] a, input logic hx,
                       input logic [3:0] pe, input logic [19:0] ma);
        @(posedge ref_clk);
        go   <= 1'b1;
        wr   <= w;
        addr <= a;
        wd   <= a[7:0] ^ 8'h5A;
        @(posedge ref_clk);
        go <= 1'b0;
        #1;
        chk({mem_req.valid, hit}, {hx, hx});
        if (hx) begin
            chk({mem_req.plane_en, mem_req.write}, {pe, w});
            chk(mem_req.addr, ma);
            if (w) chk(mem_req.wdata, a[7:0] ^ 8'h5A);
        end
    endtask

    task automatic text_windows();
        mode <= HWM_MAP_TEXT;
        mono <= 1'b0;
        req(1'b1, 20'hB8001, 1'b1, HWM_PLANE_ATTR, 20'h00000);
        req(1'b1, 20'hB8006, 1'b1, HWM_PLANE_CHAR, 20'h00003);
        req(1'b1, 20'hB7FFF, 1'b0, 4'h0, 20'h00000);
        mono <= 1'b1;
        req(1'b1, 20'hB0005, 1'b1, HWM_PLANE_ATTR, 20'h00002);
        req(1'b1, 20'hB8000, 1'b0, 4'h0, 20'h00000);
    endtask

    task automatic planar_paging();
        mode <= HWM_MAP_PLANAR;
        ext  <= 1'b1;
        wide <= 1'b0;
        ppg  <= 4'h5; // Page loaded before the access
        req(1'b1, 20'hA1234, 1'b1, HWM_ALL_PLANES, 20'h51234);
        ppg <= 4'hF;
        req(1'b0, 20'hAFFFF, 1'b1, HWM_ALL_PLANES, 20'hFFFFF);
        req(1'b0, 20'hB0000, 1'b0, 4'h0, 20'h00000);
        wide <= 1'b1;
        req(1'b1, 20'hB1234, 1'b1, HWM_ALL_PLANES, 20'h11234);
        wide <= 1'b0;
        ext  <= 1'b0;
        a1w  <= 4'h3;
        req(1'b1, 20'hA8010, 1'b1, HWM_ALL_PLANES, 20'h18010);
    endtask

    task automatic packed_apertures();
        mode <= HWM_MAP_PACKED;
        a0r  <= 4'h7;
        a0w  <= 4'h2;
        a1r  <= 4'h9;
        req(1'b0, 20'hA0020, 1'b1, HWM_ALL_PLANES, 20'h38020);
        req(1'b1, 20'hA0020, 1'b1, HWM_ALL_PLANES, 20'h10020);
        req(1'b0, 20'hA8000, 1'b1, HWM_ALL_PLANES, 20'h48000);
    endtask

    // Character fetch: code plus attribute address the font, attribute is decoded
    task automatic text_fetch(input logic [7:0] at, input logic [2:0] fs, input logic bl,
                              input logic ph);
        mode <= HWM_MAP_TEXT;
        fsel <= 6'h2D;
        @(posedge ref_clk);
        fetch <= 1'b1;
        blink <= bl;
        bph   <= ph;
        p0    <= 8'hC3;
        p1    <= at;
        row   <= 5'h0B;
        @(posedge ref_clk);
        fetch <= 1'b0;
        #1;
        chk({fvalid, faddr}, {1'b1, fs, 8'hC3, 5'h0B, 2'b00});
        chk({attr.bg_r, attr.bg_g, attr.bg_b, attr.fg_r, attr.fg_g, attr.fg_b},
            {at[6:4], at[2:0]});
        chk({attr.fg_hi, attr.bg_hi}, {at[3], at[7] & ~bl});
        chk({attr.fg_blink, attr.font_set}, {at[7] & bl & ph, fs});
    endtask

    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        text_windows();
        planar_paging();
        packed_apertures();
        text_fetch(8'hAD, 3'h7, 1'b0, 1'b0);
        text_fetch(8'h52, 3'h1, 1'b0, 1'b0);
        text_fetch(8'hAD, 3'h7, 1'b1, 1'b1);
        text_fetch(8'hD2, 3'h1, 1'b1, 1'b0);
        tally_and_finish();
    end
endmodule // test_vga_host_window_mapper
